// [hw/rc_servo_consts.vh]
// constants for the remote-control channel to servo pulse mapper
`ifndef RC_SERVO_CONSTS_VH
`define RC_SERVO_CONSTS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ          25
`define CYC_PER_US       (`CLK_MHZ)
`define FRAME_MS         20
`define FRAME_US         (`FRAME_MS * 1000)
`define STEP_MAX         4'd8
`define STEP_CENTRE      4'd4

// ----------------------------------------------------------------------
// pulse widths in microseconds
// ----------------------------------------------------------------------
`define W_MIN_RST        16'h03e8
`define W_MAX_RST        16'h07d0
`define W_CTR_RST        16'h05dc

// ----------------------------------------------------------------------
// channels and ports
// ----------------------------------------------------------------------
`define NUM_CH           32
`define NUM_PORT         8
`define CH_LEFT          5
`define CH_RSUM          6
`define CH_GEAR          7
`define CH_HOME          9
`define CH_REC           10
`define CH_SHUT          11
`define CH_PLAY          12
`define CH_CUST1         13
`define CH_CUST2         14
`define CH_LSHIFT        15
`define CH_RPSUM         16
`define CH_RPUSH         21
`define CH_RPULSE        22
`define ROUTE_NONE       4'hf

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define A_MIN_BASE       12'h000
`define A_MAX_BASE       12'h080
`define A_ROUTE_BASE     12'h100
`define A_CTRL           12'h180
`define A_STAT           12'h184
`define CTRL_RST         32'h0000_0001
`define CTRL_EN_BIT      0

`endif

// [hw/rc_servo_mapper.v]
// remote-control channel to servo pulse mapper with apb register file
//
// Summary of operation
// - left wheel maps continuously between min and max
// - right wheel steps summed, eight steps full range
// - summed channel starts centre, four steps per side
// - summed channel saturates at its limits
// - gear switch gives min or max
// - momentary buttons give max pressed, centre released
// - playback then go-home requests safe shutdown
// - playback then record requests restart
// - playback shifts left wheel, record, go-home
// - shifted left wheel follows wheel while playback held
// - shifted left wheel holds value after release
// - pushed summed channel steps only while pushed
// - push channel shows wheel press state only
// - pulse channel min down, max up, else centre
// - routing table sends each channel to one port or to none
// - centre is midpoint of min and max
`timescale 1ns/1ps
`default_nettype none
`include "rc_servo_consts.vh"

module rc_servo_mapper #(
    parameter FRAME_CYC = `FRAME_US * `CYC_PER_US
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg         pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire [9:0]  left_wheel_pos,
    input  wire        right_step,
    input  wire        right_step_up,
    input  wire        right_pushed,
    input  wire        gear_switch,
    input  wire        go_home_btn,
    input  wire        record_btn,
    input  wire        shutter_btn,
    input  wire        playback_btn,
    input  wire        custom_button_one,
    input  wire        custom_button_two,
    output reg  [7:0]  servo_out,
    output reg         shutdown_req,
    output reg         restart_req
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function [15:0] scale;
        input [15:0] lo;
        input [15:0] hi;
        input [9:0]  num;
        input [3:0]  sh;
        reg   [25:0] prod;
        begin
            prod  = (hi - lo) * num;
            prod  = prod >> sh;
            scale = lo + prod[15:0];
        end
    endfunction

    function [15:0] mid;
        input [15:0] lo;
        input [15:0] hi;
        reg   [16:0] s;
        begin
            s   = {1'b0, lo} + {1'b0, hi};
            mid = s[16:1];
        end
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg  [15:0] min_r   [0:`NUM_CH-1];
    reg  [15:0] max_r   [0:`NUM_CH-1];
    reg  [3:0]  route_r [0:`NUM_CH-1];
    reg  [15:0] prev_r  [0:`NUM_CH-1];
    reg  [15:0] port_r  [0:`NUM_PORT-1];
    reg  [15:0] frame_w_r [0:`NUM_PORT-1];
    reg  [31:0] ctrl_r;
    reg  [9:0]  left_r;
    reg  [9:0]  shift_r;
    reg  [3:0]  rsum_r;
    reg  [3:0]  rpsum_r;
    reg  [1:0]  rpulse_r;
    reg         play_d_r;
    reg         home_d_r;
    reg         rec_d_r;
    reg         play_first_r;
    reg         step_d_r;
    reg  [22:0] frame_cnt_r;
    reg  [4:0]  us_div_r;
    reg  [15:0] us_cnt_r;
    reg  [15:0] val     [0:`NUM_CH-1];
    integer     i, ci, ri, fi;

    wire frame_start = (frame_cnt_r == 23'd0);

    // ------------------------------------------------------------------
    // route reset table
    // ------------------------------------------------------------------
    function [3:0] route_rst;
        input integer ch;
        begin
            case (ch)
                `CH_LEFT:   route_rst = 4'h1;
                `CH_RSUM:   route_rst = 4'h3;
                `CH_REC:    route_rst = 4'h5;
                `CH_SHUT:   route_rst = 4'h4;
                `CH_CUST1:  route_rst = 4'h6;
                `CH_CUST2:  route_rst = 4'h7;
                `CH_LSHIFT: route_rst = 4'h2;
                default:    route_rst = `ROUTE_NONE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------------
    wire       setup  = psel & ~penable;
    wire       access = psel & penable;
    wire [4:0] idx    = paddr[6:2];
    wire [1:0] grp    = paddr[8:7];
    wire       hit_tab = (paddr[11:9] == 3'd0) && (paddr[1:0] == 2'd0)
                         && (grp != 2'd3);
    wire       hit_ctl = (paddr == `A_CTRL) || (paddr == `A_STAT);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            ctrl_r  <= `CTRL_RST;
            for (i = 0; i < `NUM_CH; i = i + 1) begin
                min_r[i]   <= `W_MIN_RST;
                max_r[i]   <= `W_MAX_RST;
                route_r[i] <= route_rst(i);
            end
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= ~(hit_tab | hit_ctl);
                prdata  <= 32'h0000_0000;
                if (hit_tab && grp == 2'd0)
                    prdata <= {16'h0000, min_r[idx]};
                else if (hit_tab && grp == 2'd1)
                    prdata <= {16'h0000, max_r[idx]};
                else if (hit_tab && grp == 2'd2)
                    prdata <= {28'h0000000, route_r[idx]};
                else if (paddr == `A_CTRL)
                    prdata <= ctrl_r;
                else if (paddr == `A_STAT)
                    prdata <= {8'h00, rpulse_r, play_first_r,
                               1'b0, rpsum_r, rsum_r, shift_r, 2'b00};
            end
            if (access && pwrite && hit_tab) begin
                case (grp)
                    2'd0:    min_r[idx]   <= pwdata[15:0];
                    2'd1:    max_r[idx]   <= pwdata[15:0];
                    default: route_r[idx] <= pwdata[3:0];
                endcase
            end
            if (access && pwrite && paddr == `A_CTRL)
                ctrl_r <= pwdata;
        end
    end

    // ------------------------------------------------------------------
    // controller event state
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r       <= 10'h200;
            shift_r      <= 10'h200;
            rsum_r       <= `STEP_CENTRE;
            rpsum_r      <= `STEP_CENTRE;
            rpulse_r     <= 2'b00;
            step_d_r     <= 1'b0;
            play_d_r     <= 1'b0;
            home_d_r     <= 1'b0;
            rec_d_r      <= 1'b0;
            play_first_r <= 1'b0;
            shutdown_req <= 1'b0;
            restart_req  <= 1'b0;
        end else begin
            play_d_r <= playback_btn;
            step_d_r <= right_step;
            home_d_r <= go_home_btn;
            rec_d_r  <= record_btn;
            // shift only counts when playback came before the other key
            if (!playback_btn)
                play_first_r <= 1'b0;
            else if (!play_d_r && !go_home_btn && !record_btn)
                play_first_r <= 1'b1;
            shutdown_req <= play_first_r & playback_btn
                            & go_home_btn & ~home_d_r;
            restart_req  <= play_first_r & playback_btn
                            & record_btn & ~rec_d_r;
            if (playback_btn)
                shift_r <= left_wheel_pos;
            else
                left_r  <= left_wheel_pos;
            if (right_step && !right_pushed) begin
                if (right_step_up && rsum_r != `STEP_MAX)
                    rsum_r <= rsum_r + 4'd1;
                else if (!right_step_up && rsum_r != 4'd0)
                    rsum_r <= rsum_r - 4'd1;
            end
            if (right_step && right_pushed) begin
                if (right_step_up && rpsum_r != `STEP_MAX)
                    rpsum_r <= rpsum_r + 4'd1;
                else if (!right_step_up && rpsum_r != 4'd0)
                    rpsum_r <= rpsum_r - 4'd1;
            end
            // a step beats the frame-end clear so no pulse is lost;
            // a step one edge old has not reached its port register yet
            if (right_step)
                rpulse_r <= right_step_up ? 2'b10 : 2'b01;
            else if (frame_start && !step_d_r)
                rpulse_r <= 2'b00;
        end
    end

    // ------------------------------------------------------------------
    // channel values in microseconds
    // ------------------------------------------------------------------
    always @* begin
        for (ci = 0; ci < `NUM_CH; ci = ci + 1)
            val[ci] = mid(min_r[ci], max_r[ci]);
        val[`CH_LEFT]   = scale(min_r[`CH_LEFT], max_r[`CH_LEFT],
                                left_r, 4'd10);
        val[`CH_LSHIFT] = scale(min_r[`CH_LSHIFT], max_r[`CH_LSHIFT],
                                shift_r, 4'd10);
        val[`CH_RSUM]   = scale(min_r[`CH_RSUM], max_r[`CH_RSUM],
                                {6'd0, rsum_r}, 4'd3);
        val[`CH_RPSUM]  = scale(min_r[`CH_RPSUM], max_r[`CH_RPSUM],
                                {6'd0, rpsum_r}, 4'd3);
        val[`CH_GEAR]   = gear_switch ? max_r[`CH_GEAR]
                                      : min_r[`CH_GEAR];
        if (go_home_btn && !play_first_r)
            val[`CH_HOME]  = max_r[`CH_HOME];
        if (record_btn && !play_first_r)
            val[`CH_REC]   = max_r[`CH_REC];
        if (shutter_btn)
            val[`CH_SHUT]  = max_r[`CH_SHUT];
        if (playback_btn)
            val[`CH_PLAY]  = max_r[`CH_PLAY];
        if (custom_button_one)
            val[`CH_CUST1] = max_r[`CH_CUST1];
        if (custom_button_two)
            val[`CH_CUST2] = max_r[`CH_CUST2];
        if (right_pushed)
            val[`CH_RPUSH] = max_r[`CH_RPUSH];
        if (rpulse_r[1])
            val[`CH_RPULSE] = max_r[`CH_RPULSE];
        else if (rpulse_r[0])
            val[`CH_RPULSE] = min_r[`CH_RPULSE];
    end

    // ------------------------------------------------------------------
    // routing: a port takes the latest change of any channel on it
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (ri = 0; ri < `NUM_CH; ri = ri + 1)
                prev_r[ri] <= `W_CTR_RST;
            for (ri = 0; ri < `NUM_PORT; ri = ri + 1)
                port_r[ri] <= `W_CTR_RST;
        end else begin
            for (ri = 0; ri < `NUM_CH; ri = ri + 1) begin
                prev_r[ri] <= val[ri];
                // unrouted when the route field is negative
                if (val[ri] != prev_r[ri] && !route_r[ri][3])
                    port_r[route_r[ri][2:0]] <= val[ri];
            end
        end
    end

    // ------------------------------------------------------------------
    // servo frame generator
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_r <= 23'd0;
            us_div_r    <= 5'd0;
            us_cnt_r    <= 16'h0000;
            servo_out   <= 8'h00;
            for (fi = 0; fi < `NUM_PORT; fi = fi + 1)
                frame_w_r[fi] <= `W_CTR_RST;
        end else begin
            if (frame_cnt_r == FRAME_CYC[22:0] - 23'd1)
                frame_cnt_r <= 23'd0;
            else
                frame_cnt_r <= frame_cnt_r + 23'd1;
            if (frame_start || us_div_r == `CYC_PER_US - 1)
                us_div_r <= 5'd0;
            else
                us_div_r <= us_div_r + 5'd1;
            if (frame_start)
                us_cnt_r <= 16'h0000;
            else if (us_div_r == `CYC_PER_US - 1)
                us_cnt_r <= us_cnt_r + 16'h0001;
            for (fi = 0; fi < `NUM_PORT; fi = fi + 1) begin
                // width changes only at a frame edge, never mid-pulse
                if (frame_start)
                    frame_w_r[fi] <= port_r[fi];
                // low at each frame edge: a width longer than the
                // frame is cut short but every frame start still shows
                servo_out[fi] <= ctrl_r[`CTRL_EN_BIT] && !frame_start &&
                                 (us_cnt_r < frame_w_r[fi]);
            end
        end
    end

endmodule
`default_nettype wire

// [test/rc_servo_mapper_properties.sv]
// port assertions for the servo pulse mapper
`timescale 1ns/1ps
`default_nettype none
module rc_servo_mapper_props #(
    parameter FRAME_CYC = 500000
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       go_home_btn,
    input wire logic       record_btn,
    input wire logic       playback_btn,
    input wire logic [7:0] servo_out,
    input wire logic       shutdown_req,
    input wire logic       restart_req
);
    logic [7:0]  prev_r;
    logic [31:0] gap_r;
    logic        seen_r;
    logic        rise;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // all ports start together, so any rise from all-low is a frame start
    assign rise = (prev_r == 8'h00) && (servo_out != 8'h00);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 8'h00;
            gap_r  <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            prev_r <= servo_out;
            gap_r  <= rise ? 32'h0 : gap_r + 32'h1;
            seen_r <= seen_r | rise;
        end
    end
    sequence s_play_first;
        (playback_btn && !go_home_btn && !record_btn) [*2];
    endsequence
    sequence s_home_join;
        s_play_first ##1 (playback_btn && go_home_btn);
    endsequence
    sequence s_rec_join;
        s_play_first ##1 (playback_btn && record_btn);
    endsequence
    a_shut_combo: assert property (s_home_join |-> ##[1:3] shutdown_req)
        else $error("shutdown missing after combination");
    a_shut_cause: assert property (
        shutdown_req |-> $past(playback_btn) && $past(go_home_btn))
        else $error("shutdown without combination");
    a_shut_single: assert property (shutdown_req |=> !shutdown_req)
        else $error("shutdown pulse too long");
    a_rest_combo: assert property (s_rec_join |-> ##[1:3] restart_req)
        else $error("restart missing after combination");
    a_rest_cause: assert property (
        restart_req |-> $past(playback_btn) && $past(record_btn))
        else $error("restart without combination");
    a_rest_single: assert property (restart_req |=> !restart_req)
        else $error("restart pulse too long");
    a_shift_held: assert property (
        (shutdown_req || restart_req) |-> $past(playback_btn, 2))
        else $error("request without held playback");
    a_frame_gap: assert property (
        rise && seen_r |-> gap_r == FRAME_CYC - 1)
        else $error("frame period wrong");
    a_start_sync: assert property (
        (servo_out & ~prev_r) != 8'h00 |-> prev_r == 8'h00)
        else $error("pulse started mid frame");
endmodule
bind rc_servo_mapper rc_servo_mapper_props #(.FRAME_CYC(FRAME_CYC)) props_u (
    .pclk(pclk),
    .presetn(presetn),
    .go_home_btn(go_home_btn),
    .record_btn(record_btn),
    .playback_btn(playback_btn),
    .servo_out(servo_out),
    .shutdown_req(shutdown_req),
    .restart_req(restart_req)
);
`default_nettype wire

// [test/servo_sink.sv]
// servo receiver model: measures each port's pulse in clock cycles
`timescale 1ns/1ps
`default_nettype none
module servo_sink (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [7:0]   servo_out,
    output var  logic [127:0] widths
);
    logic [15:0] cnt [8];
    // a servo takes one width per frame, latched as the pulse ends
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            widths <= '0;
            for (int i = 0; i < 8; i++) cnt[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (servo_out[i]) begin
                    cnt[i] <= cnt[i] + 16'h0001;
                end else if (cnt[i] != 16'h0000) begin
                    widths[i*16 +: 16] <= cnt[i];
                    cnt[i] <= 16'h0000;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [test/tb_rc_control_to_servo_pwm_mapper.sv]
// self-checking bench for the servo pulse mapper
`timescale 1ns/1ps
`default_nettype none
`include "rc_servo_consts.vh"
module tb_rc_control_to_servo_pwm_mapper;
    localparam int F  = 2500;
    localparam int LO = 8;
    localparam int HI = 40;
    logic         pclk, presetn, psel, penable, pwrite, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, rd, r;
    logic [31:0]  seed = 32'd56;
    logic [9:0]   wheel;
    logic [3:0]   ps;
    logic         rstep, rup, rpush, gear, home, rec, shut, play, cb1, cb2;
    wire          pready, pslverr, shutdown_req, restart_req;
    wire  [31:0]  prdata;
    wire  [7:0]   servo_out;
    wire  [127:0] widths;
    int           n_fail = 0, n_checks = 0, n_shut = 0, n_rest = 0;
    rc_servo_mapper #(.FRAME_CYC(F)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .left_wheel_pos(wheel),
        .right_step(rstep), .right_step_up(rup), .right_pushed(rpush),
        .gear_switch(gear), .go_home_btn(home), .record_btn(rec),
        .shutter_btn(shut), .playback_btn(play),
        .custom_button_one(cb1), .custom_button_two(cb2),
        .servo_out(servo_out), .shutdown_req(shutdown_req),
        .restart_req(restart_req));
    servo_sink sink_u (.pclk(pclk), .presetn(presetn),
        .servo_out(servo_out), .widths(widths));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] cyc(input int us);
        return us * `CYC_PER_US;
    endfunction
    function automatic int w_cont(input logic [9:0] pos);
        return LO + ((HI - LO) * pos) / 1024;
    endfunction
    function automatic int btn(input logic p);
        return p ? HI : (LO + HI) / 2;
    endfunction
    function automatic logic [3:0] nstep(input logic [3:0] s, input logic u);
        if (u) return (s == 4'd8) ? s : s + 4'd1;
        return (s == 4'd0) ? s : s - 4'd1;
    endfunction
    function automatic logic [31:0] pw(input int p);
        return {16'h0000, widths[p*16 +: 16]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input logic ee);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, err}, {31'h0, ee});
    endtask
    task automatic step(input logic up, input logic push);
        @(posedge pclk);
        rstep <= 1'b1;
        rup <= up;
        rpush <= push;
        @(posedge pclk);
        rstep <= 1'b0;
    endtask
    task automatic frames();
        repeat (2 * F + 50) @(posedge pclk);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (shutdown_req === 1'b1) n_shut++;
        if (restart_req === 1'b1) n_rest++;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        results();
    end
    initial begin
        {psel, penable, pwrite, rstep, rup, rpush, gear} = '0;
        {home, rec, shut, play, cb1, cb2} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        wheel = 10'h000;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`A_MIN_BASE, {16'h0000, `W_MIN_RST}, 1'b0);
        rdchk(`A_MAX_BASE + 12'h014, {16'h0000, `W_MAX_RST}, 1'b0);
        rdchk(`A_ROUTE_BASE + 12'h014, 32'h1, 1'b0);
        rdchk(`A_ROUTE_BASE + 12'h018, 32'h3, 1'b0);
        rdchk(`A_ROUTE_BASE, {28'h0, `ROUTE_NONE}, 1'b0);
        rdchk(`A_CTRL, `CTRL_RST, 1'b0);
        rdchk(12'h188, 32'h0, 1'b1);
        apb(1'b0, `A_STAT, 32'h0);
        chk(rd[19:12], 8'h44);
        $display("test reset values done");
        // route first: a port only follows a channel's later changes
        apb(1'b1, `A_ROUTE_BASE + 12'h01c, 32'hffff_fff0);
        // narrow limits keep every pulse well inside the short frame
        for (int c = 0; c < 32; c++) begin
            apb(1'b1, `A_MIN_BASE + 12'(4 * c), 32'hffff_0000 | LO);
            apb(1'b1, `A_MAX_BASE + 12'(4 * c), HI);
        end
        rdchk(`A_MIN_BASE + 12'h07c, LO, 1'b0);
        rdchk(`A_ROUTE_BASE + 12'h01c, 32'h0, 1'b0);
        for (int i = 0; i < 5; i++) step(1'b0, 1'b0);
        apb(1'b0, `A_STAT, 32'h0);
        chk(rd[19:12], 8'h40);
        for (int i = 0; i < 9; i++) step(1'b1, 1'b0);
        apb(1'b0, `A_STAT, 32'h0);
        chk(rd[15:12], 4'h8);
        ps = 4'd4;
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            step(r[0], 1'b1);
            ps = nstep(ps, r[0]);
        end
        for (int i = 0; i < 11; i++) step(i < 9, 1'b0);
        apb(1'b0, `A_STAT, 32'h0);
        chk(rd[19:12], {ps, 4'h6});
        $display("test wheel steps done");
        for (int k = 0; k < 3; k++) begin
            r = rnd();
            if (k == 0) r[9:0] = 10'h200;
            @(posedge pclk);
            wheel <= r[9:0];
            gear <= r[10];
            rec <= r[11];
            shut <= r[12];
            cb1 <= r[13];
            cb2 <= r[14];
            frames();
            chk(pw(1), cyc(w_cont(r[9:0])));
            chk(pw(0), cyc(r[10] ? HI : LO));
            chk(pw(5), cyc(btn(r[11])));
            chk(pw(4), cyc(btn(r[12])));
            chk(pw(6), cyc(btn(r[13])));
            chk(pw(7), cyc(btn(r[14])));
            chk(pw(3), cyc(LO + 24));
        end
        apb(1'b1, `A_ROUTE_BASE + 12'h054, 32'h0);
        @(posedge pclk);
        rpush <= 1'b1;
        frames();
        chk(pw(0), cyc(HI));
        rpush <= 1'b0;
        $display("test channel widths done");
        r = rnd();
        rec <= 1'b0;
        play <= 1'b1;
        repeat (3) @(posedge pclk);
        wheel <= r[9:0];
        repeat (3) @(posedge pclk);
        play <= 1'b0;
        @(posedge pclk);
        wheel <= ~r[9:0];
        frames();
        apb(1'b0, `A_STAT, 32'h0);
        chk(rd[11:2], r[9:0]);
        chk(pw(2), cyc(w_cont(r[9:0])));
        chk(pw(1), cyc(w_cont(~r[9:0])));
        $display("test shifted wheel done");
        home <= 1'b1;
        repeat (3) @(posedge pclk);
        play <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(n_shut, 0);
        for (int m = 0; m < 2; m++) begin
            home <= 1'b0;
            rec <= 1'b0;
            play <= 1'b0;
            repeat (4) @(posedge pclk);
            play <= 1'b1;
            repeat (4) @(posedge pclk);
            if (m == 0) rec <= 1'b1;
            else home <= 1'b1;
            repeat (8) @(posedge pclk);
            chk(n_rest, 1);
            chk(n_shut, m);
        end
        $display("test combinations done");
        results();
    end
endmodule
`default_nettype wire
